//--- rtl/mb_cfg_regs.sv
// Configuration registers, slave address, restore and watchdog control.
// Assumes a frame engine on the same clock that presents decoded
// register and bit requests and pulses its message events.
// Functional notes
// - switch weights 1,2,4,8,16 form address 0-31
// - addresses 32-255 only by register write
// - four variable spaces, bit and word access
// - all stored data in 16-bit registers
// - factory: 19200, no parity, 8N1, RTU
// - restore switch at power-up, flash LEDs
// - restore also clears all register values
// - baud codes 0-6 tabled, else value*10
// - parity codes none, odd, even, one, zero
// - stop count low byte, data high byte
// - reply delay register in milliseconds
// - mode 0 RTU, 1 ASCII
// - 16-bit watchdog timeout in ms since message
// - timeout forces outputs to default state
// - watchdog defaults to zero, zero disables
// - comm LED lit while replying to good packet
// - one LED per output, lit when on
// - default pattern loaded at power-up and timeout
module mb_cfg_regs #(
  parameter int unsigned N_OUT     = 16,
  parameter int unsigned MS_CYCLES = mb_cfg_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // switch pins, active high when ON
  input  wire logic [4:0]               addr_switch_i,
  input  wire logic                     factory_restore_switch_i,
  // request port from the frame engine
  input  wire logic                     req_i,
  input  wire logic                     req_write_i,
  input  wire logic                     req_bit_i,
  input  wire logic [15:0]              req_addr_i,
  input  wire logic [15:0]              req_wdata_i,
  output logic                          ack_o,
  output logic [15:0]                   rdata_o,
  output logic                          fault_o,
  // message events from the frame engine
  input  wire logic                     rx_ok_i,
  input  wire logic                     rx_err_i,
  input  wire logic                     tx_done_i,
  input  wire logic                     replying_i,
  // decoded settings
  output logic [7:0]                    slave_addr_o,
  output logic [19:0]                   baud_rate_o,
  output mb_cfg_pkg::parity_e           parity_o,
  output logic                          two_stop_o,
  output logic                          seven_data_o,
  output logic [15:0]                   reply_delay_ms_o,
  output logic                          ascii_mode_o,
  output logic                          config_ready_o,
  // outputs and indicators
  output logic [N_OUT-1:0]              outputs_o,
  output logic [N_OUT-1:0]              out_led_o,
  output logic                          power_led_o,
  output logic                          comm_led_o
);
  import mb_cfg_pkg::*;

  initial begin
    if (N_OUT < 1 || N_OUT > 16) $error("mb_cfg_regs: N_OUT out of range");
  end

  typedef enum logic [2:0] {
    ST_SETTLE  = 3'b001,
    ST_RESTORE = 3'b010,
    ST_RUN     = 3'b100
  } boot_e;

  // synchronised switches
  logic [5:0] sw_s;

  sync2 #(.W(6)) u_sw_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({factory_restore_switch_i, addr_switch_i}),
    .q_o     (sw_s)
  );

  wire [4:0] sw_addr    = sw_s[4:0];
  wire       sw_restore = sw_s[5];

  // watchdog timer
  wdog_if wd ();

  wdog_timer #(.MS_CYCLES(MS_CYCLES)) u_wdog (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .wd      (wd.timer)
  );

  // register state
  logic [15:0]      baud_q, frame_q, parity_q, delay_q, mode_q, wdog_q;
  logic [N_OUT-1:0] def_out_q, out_q;
  logic [7:0]       soft_addr_q;
  logic [31:0]      rx_cnt_q, err_cnt_q, tx_cnt_q;
  boot_e            state_q;
  logic [1:0]       settle_q;
  logic [7:0]       flash_ms_q;
  logic             flash_q;

  // request decode
  wire run       = (state_q == ST_RUN);
  wire clear_all = !run;
  wire wr        = req_i && req_write_i && run;
  wire rd        = req_i && !req_write_i;
  wire wr_word   = wr && !req_bit_i;
  wire [3:0] bidx = req_addr_i[3:0];
  wire bit_def   = (req_addr_i[15:4] == (BIT_DEF_BASE >> 4)) && (5'(bidx) < 5'(N_OUT));
  wire bit_out   = (req_addr_i[15:4] == (BIT_OUT_BASE >> 4)) && (5'(bidx) < 5'(N_OUT));
  wire bit_val   = req_wdata_i[0];

  wire wr_baud   = wr_word && (req_addr_i == REG_BAUD);
  wire wr_frame  = wr_word && (req_addr_i == REG_FRAME);
  wire wr_parity = wr_word && (req_addr_i == REG_PARITY);
  wire wr_delay  = wr_word && (req_addr_i == REG_DELAY);
  wire wr_mode   = wr_word && (req_addr_i == REG_MODE);
  wire wr_wdog   = wr_word && (req_addr_i == REG_WATCHDOG);
  wire wr_def    = wr_word && (req_addr_i == REG_DEF_OUT);
  wire wr_soft   = wr_word && (req_addr_i == REG_SOFT_ADDR);
  wire wr_out    = wr_word && (req_addr_i == REG_OUTPUTS);
  wire wr_def_b  = wr && req_bit_i && bit_def;
  wire wr_out_b  = wr && req_bit_i && bit_out;

  // word read mux, the switch and version words are read-only
  logic [15:0] word_rd;
  logic        word_hit;
  logic        word_ro;

  always_comb begin
    word_rd  = 16'h0000;
    word_hit = 1'b1;
    word_ro  = 1'b0;
    case (req_addr_i)
      REG_VERSION:   begin word_rd = VERSION_TYPE;        word_ro = 1'b1; end
      REG_SWITCHES:  begin word_rd = {10'h000, sw_s};     word_ro = 1'b1; end
      REG_BAUD:      word_rd = baud_q;
      REG_FRAME:     word_rd = frame_q;
      REG_PARITY:    word_rd = parity_q;
      REG_DELAY:     word_rd = delay_q;
      REG_MODE:      word_rd = mode_q;
      REG_WATCHDOG:  word_rd = wdog_q;
      REG_DEF_OUT:   word_rd = 16'(def_out_q);
      REG_SOFT_ADDR: word_rd = {8'h00, soft_addr_q};
      REG_RX_MSB:    word_rd = rx_cnt_q[31:16];
      REG_RX_LSB:    word_rd = rx_cnt_q[15:0];
      REG_ERR_MSB:   word_rd = err_cnt_q[31:16];
      REG_ERR_LSB:   word_rd = err_cnt_q[15:0];
      REG_TX_MSB:    word_rd = tx_cnt_q[31:16];
      REG_TX_LSB:    word_rd = tx_cnt_q[15:0];
      REG_OUTPUTS:   word_rd = 16'(out_q);
      default:       word_hit = 1'b0;
    endcase
  end

  wire        bit_hit  = bit_def || bit_out;
  wire        bit_rd   = bit_def ? def_out_q[bidx] : (bit_out && out_q[bidx]);
  wire        hit      = req_bit_i ? bit_hit : word_hit;
  wire [15:0] rd_value = req_bit_i ? {15'h0000, bit_rd} : word_rd;
  // restore phase and read-only words refuse writes
  wire        refused  = !hit || (req_write_i && (!run || (!req_bit_i && word_ro)));

  // request answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 16'h0000;
      fault_o <= 1'b0;
    end else begin
      ack_o   <= req_i;
      rdata_o <= (rd && hit) ? rd_value : 16'h0000;
      fault_o <= req_i && refused;
    end
  end

  // let the synchroniser settle before the restore switch is looked at
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q  <= ST_SETTLE;
      settle_q <= '0;
    end else begin
      case (state_q)
        ST_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == 2'(SETTLE_CYCLES - 1)) begin
            state_q <= sw_restore ? ST_RESTORE : ST_RUN;
          end
        end
        ST_RESTORE: if (!sw_restore) state_q <= ST_RUN;
        ST_RUN:     state_q <= ST_RUN;
        default:    state_q <= ST_SETTLE;
      endcase
    end
  end

  // flash clock for the restore indication
  always_ff @(posedge clk_i) begin
    if (reset_i || state_q != ST_RESTORE) begin
      flash_ms_q <= '0;
      flash_q    <= 1'b1;
    end else if (wd.ms_tick) begin
      if (flash_ms_q == 8'(FLASH_HALF_MS - 1)) begin
        flash_ms_q <= '0;
        flash_q    <= !flash_q;
      end else begin
        flash_ms_q <= flash_ms_q + 8'h01;
      end
    end
  end

  // configuration words; restore holds them at factory values
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_all) begin
      baud_q      <= RST_BAUD;
      frame_q     <= RST_FRAME;
      parity_q    <= RST_PARITY;
      delay_q     <= RST_DELAY;
      mode_q      <= RST_MODE;
      wdog_q      <= RST_WATCHDOG;
      def_out_q   <= N_OUT'(RST_DEF_OUT);
      soft_addr_q <= 8'h00;
    end else begin
      if (wr_baud)   baud_q   <= req_wdata_i;
      if (wr_frame)  frame_q  <= req_wdata_i;
      if (wr_parity) parity_q <= req_wdata_i;
      if (wr_delay)  delay_q  <= req_wdata_i;
      if (wr_mode)   mode_q   <= req_wdata_i;
      if (wr_wdog)   wdog_q   <= req_wdata_i;
      if (wr_def)    def_out_q <= req_wdata_i[N_OUT-1:0];
      if (wr_def_b)  def_out_q[bidx] <= bit_val;
      // only 32..255 is kept; anything else hands the address back to the switches
      if (wr_soft) begin
        soft_addr_q <= (req_wdata_i[15:8] == 8'h00 && req_wdata_i[7:0] >= SOFT_ADDR_MIN)
                       ? req_wdata_i[7:0] : 8'h00;
      end
    end
  end

  // default pattern at power-up and on expiry; expiry beats a write
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_all) begin
      out_q <= N_OUT'(RST_DEF_OUT);
    end else if (wd.expire) begin
      out_q <= def_out_q;
    end else if (wr_out) begin
      out_q <= req_wdata_i[N_OUT-1:0];
    end else if (wr_out_b) begin
      out_q[bidx] <= bit_val;
    end
  end

  // packet counters; a write loads a half and a same-cycle event still counts
  wire [31:0] rx_base  = wr_word && req_addr_i == REG_RX_MSB ? {req_wdata_i, rx_cnt_q[15:0]} :
                         wr_word && req_addr_i == REG_RX_LSB ? {rx_cnt_q[31:16], req_wdata_i} :
                         rx_cnt_q;
  wire [31:0] err_base = wr_word && req_addr_i == REG_ERR_MSB ? {req_wdata_i, err_cnt_q[15:0]} :
                         wr_word && req_addr_i == REG_ERR_LSB ? {err_cnt_q[31:16], req_wdata_i} :
                         err_cnt_q;
  wire [31:0] tx_base  = wr_word && req_addr_i == REG_TX_MSB ? {req_wdata_i, tx_cnt_q[15:0]} :
                         wr_word && req_addr_i == REG_TX_LSB ? {tx_cnt_q[31:16], req_wdata_i} :
                         tx_cnt_q;

  always_ff @(posedge clk_i) begin
    if (reset_i || clear_all) begin
      rx_cnt_q  <= '0;
      err_cnt_q <= '0;
      tx_cnt_q  <= '0;
    end else begin
      rx_cnt_q  <= rx_base + 32'(rx_ok_i);
      err_cnt_q <= err_base + 32'(rx_err_i);
      tx_cnt_q  <= tx_base + 32'(tx_done_i);
    end
  end

  // watchdog hookup; a new timeout restarts the count
  assign wd.timeout_ms = wdog_q;
  assign wd.kick       = (rx_ok_i && run) || wr_wdog;

  // setting decode
  logic [19:0] baud_d;

  always_comb begin
    case (baud_q)
      16'h0000: baud_d = 20'd2400;
      16'h0001: baud_d = 20'd4800;
      16'h0002: baud_d = 20'd9600;
      16'h0003: baud_d = 20'd19200;
      16'h0004: baud_d = 20'd38400;
      16'h0005: baud_d = 20'd57600;
      16'h0006: baud_d = 20'd115200;
      default:  baud_d = 20'(baud_q) * 20'(BAUD_SCALE);
    endcase
  end

  logic [2:0] parity_d;

  always_comb begin
    case (parity_q)
      16'h0001: parity_d = PAR_ODD;
      16'h0002: parity_d = PAR_EVEN;
      16'h0003: parity_d = PAR_MARK;
      16'h0004: parity_d = PAR_SPACE;
      default:  parity_d = PAR_NONE;
    endcase
  end

  // soft address wins when one is stored
  wire [7:0] addr_d = (soft_addr_q != 8'h00) ? soft_addr_q : {3'h0, sw_addr};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slave_addr_o     <= 8'h00;
      baud_rate_o      <= 20'd19200;
      parity_o         <= PAR_NONE;
      two_stop_o       <= 1'b0;
      seven_data_o     <= 1'b0;
      reply_delay_ms_o <= 16'h0000;
      ascii_mode_o     <= 1'b0;
      config_ready_o   <= 1'b0;
    end else begin
      slave_addr_o     <= addr_d;
      baud_rate_o      <= baud_d;
      parity_o         <= parity_e'(parity_d);
      two_stop_o       <= frame_q[STOP_LSB +: 8] == STOP_TWO;
      seven_data_o     <= frame_q[DATA_LSB +: 8] == DATA_SEVEN;
      reply_delay_ms_o <= delay_q;
      ascii_mode_o     <= mode_q == 16'h0001;
      config_ready_o   <= run;
    end
  end

  // indicators
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      outputs_o   <= N_OUT'(RST_DEF_OUT);
      out_led_o   <= '0;
      power_led_o <= 1'b0;
      comm_led_o  <= 1'b0;
    end else begin
      outputs_o   <= out_q;
      out_led_o   <= out_q;
      power_led_o <= (state_q == ST_RESTORE) ? flash_q : 1'b1;
      comm_led_o  <= (state_q == ST_RESTORE) ? flash_q : (replying_i && run);
    end
  end

endmodule : mb_cfg_regs

//--- rtl/mb_cfg_pkg.sv
// Constants of the configuration and watchdog block.
// Assumes a 20 MHz single clock and a Modbus frame engine outside this block.
package mb_cfg_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_PERIOD_NS  = 1_000_000;
  localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned SETTLE_CYCLES = 3;

  // holding and input register indices
  localparam logic [15:0] REG_VERSION   = 16'h0000;
  localparam logic [15:0] REG_SWITCHES  = 16'h0001;
  localparam logic [15:0] REG_BAUD      = 16'h0002;
  localparam logic [15:0] REG_FRAME     = 16'h0003;
  localparam logic [15:0] REG_PARITY    = 16'h0004;
  localparam logic [15:0] REG_DELAY     = 16'h0005;
  localparam logic [15:0] REG_MODE      = 16'h0006;
  localparam logic [15:0] REG_WATCHDOG  = 16'h0008;
  localparam logic [15:0] REG_DEF_OUT   = 16'h000C;
  localparam logic [15:0] REG_SOFT_ADDR = 16'h0010;
  localparam logic [15:0] REG_RX_MSB    = 16'h0020;
  localparam logic [15:0] REG_RX_LSB    = 16'h0021;
  localparam logic [15:0] REG_ERR_MSB   = 16'h0022;
  localparam logic [15:0] REG_ERR_LSB   = 16'h0023;
  localparam logic [15:0] REG_TX_MSB    = 16'h0024;
  localparam logic [15:0] REG_TX_LSB    = 16'h0025;
  localparam logic [15:0] REG_OUTPUTS   = 16'h0033;

  // bit-access bases, one bit per output in the low nibble
  localparam logic [11:0] BIT_DEF_BASE  = 12'h0C0;
  localparam logic [11:0] BIT_OUT_BASE  = 12'h330;

  // factory values
  localparam logic [15:0] RST_BAUD      = 16'h0003;
  localparam logic [15:0] RST_FRAME     = 16'h0801;
  localparam logic [15:0] RST_PARITY    = 16'h0000;
  localparam logic [15:0] RST_DELAY     = 16'h0000;
  localparam logic [15:0] RST_MODE      = 16'h0000;
  localparam logic [15:0] RST_WATCHDOG  = 16'h0000;
  localparam logic [15:0] RST_DEF_OUT   = 16'h0000;
  localparam logic [15:0] VERSION_TYPE  = 16'h0100; // arbitrary value

  // field layout and codes
  localparam int unsigned STOP_LSB      = 0;
  localparam int unsigned DATA_LSB      = 8;
  localparam logic [7:0]  STOP_TWO      = 8'h02;
  localparam logic [7:0]  DATA_SEVEN    = 8'h07;
  localparam logic [7:0]  SOFT_ADDR_MIN = 8'h20;
  localparam logic [15:0] BAUD_LAST_CODE = 16'h0006;
  localparam logic [3:0]  BAUD_SCALE    = 4'hA;

  typedef enum logic [2:0] {
    PAR_NONE = 3'h0, PAR_ODD = 3'h1, PAR_EVEN = 3'h2, PAR_MARK = 3'h3, PAR_SPACE = 3'h4
  } parity_e;

endpackage : mb_cfg_pkg

//--- rtl/wdog_if.sv
// Carrier between the register bank and its millisecond watchdog timer.
// Assumes both ends run on the same clock.
interface wdog_if;
  logic [15:0] timeout_ms;
  logic        kick;
  logic        ms_tick;
  logic        expire;

  modport ctrl  (output timeout_ms, output kick, input ms_tick, input expire);
  modport timer (input timeout_ms, input kick, output ms_tick, output expire);
endinterface : wdog_if

//--- rtl/sync2.sv
// Two-flop synchroniser for slow pin levels such as switches.
// Assumes the inputs are quasi-static; no bus coherency between bits is given.
module sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : sync2

//--- rtl/wdog_timer.sv
// Millisecond time base and communication watchdog.
// Assumes kick is a one-cycle pulse from the register bank on each valid message.
module wdog_timer #(
  parameter int unsigned MS_CYCLES = mb_cfg_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // control side
  wdog_if.timer     wd
);
  import mb_cfg_pkg::*;

  localparam int unsigned DW = $clog2(MS_CYCLES);

  logic [DW-1:0] div_q;
  logic [15:0]   elapsed_q;
  logic          tick_q;
  logic          expire_q;
  wire           div_end  = (div_q == DW'(MS_CYCLES - 1));
  wire  [15:0]   elapsed_n = elapsed_q + 16'h0001;

  initial begin
    if (MS_CYCLES < 2) $error("wdog_timer: MS_CYCLES below 2");
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_end ? '0 : div_q + DW'(1);
      tick_q <= div_end;
    end
  end

  // the count is reset, not the divider, so the timeout has up to one ms of slack
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      elapsed_q <= '0;
      expire_q  <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (wd.kick) begin
        elapsed_q <= '0;
      end else if (tick_q && elapsed_q != 16'hFFFF) begin
        elapsed_q <= elapsed_n;
        expire_q  <= (wd.timeout_ms != 16'h0000) && (elapsed_n == wd.timeout_ms);
      end
    end
  end

  assign wd.ms_tick = tick_q;
  assign wd.expire  = expire_q;
endmodule : wdog_timer

//--- tb/mb_cfg_regs_sva.sv
// Port-level checks for the configuration register bank.
// Assumes one clock domain and the synchronous active-high reset.
module mb_cfg_regs_chk #(
  parameter int unsigned N_OUT = 16
) (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             reset_i,
  // request port
  input wire logic             req_i,
  input wire logic             req_write_i,
  input wire logic             req_bit_i,
  input wire logic [15:0]      req_addr_i,
  input wire logic [15:0]      req_wdata_i,
  input wire logic             ack_o,
  input wire logic [15:0]      rdata_o,
  input wire logic             fault_o,
  // status and indicators
  input wire logic             replying_i,
  input wire logic [19:0]      baud_rate_o,
  input wire logic             ascii_mode_o,
  input wire logic             config_ready_o,
  input wire logic [N_OUT-1:0] outputs_o,
  input wire logic [N_OUT-1:0] out_led_o,
  input wire logic             power_led_o,
  input wire logic             comm_led_o
);
  import mb_cfg_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence wr_word(a);
    req_i && req_write_i && !req_bit_i && req_addr_i == a && config_ready_o;
  endsequence

  ack_timing_a: assert property (req_i |-> ##1 ack_o)
    else $error("ack missing");
  ack_cause_a: assert property (ack_o |-> $past(req_i))
    else $error("stray ack");
  refuse_ro_a: assert property (req_i && req_write_i && !req_bit_i && req_addr_i == REG_VERSION
    |=> fault_o && rdata_o == 16'h0000) else $error("ro write accepted");
  refuse_hole_a: assert property (req_i && !req_bit_i && req_addr_i == 16'h0007 |=> fault_o)
    else $error("hole not refused");
  baud_write_a: assert property (wr_word(REG_BAUD) ##0 req_wdata_i == 16'h0004
    |-> ##2 baud_rate_o == 20'd38400) else $error("baud code 4 wrong");
  mode_write_a: assert property (wr_word(REG_MODE) ##0 req_wdata_i == 16'h0001
    |-> ##2 ascii_mode_o) else $error("mode 1 not ascii");
  led_mirror_a: assert property (out_led_o == outputs_o)
    else $error("led differs");
  comm_led_a: assert property (config_ready_o && $past(config_ready_o)
    |-> comm_led_o == $past(replying_i)) else $error("comm led wrong");
  reset_vals_a: assert property ($fell(reset_i) |-> baud_rate_o == 20'd19200
    && outputs_o == '0) else $error("reset values wrong");
  power_on_a: assert property ($fell(reset_i) |-> ##[0:1] power_led_o)
    else $error("power led off");
  wr_refused_a: assert property (req_i && req_write_i && !config_ready_o |=> fault_o)
    else $error("early write taken");
endmodule : mb_cfg_regs_chk

bind mb_cfg_regs mb_cfg_regs_chk #(.N_OUT(N_OUT)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .req_write_i(req_write_i),
  .req_bit_i(req_bit_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
  .ack_o(ack_o), .rdata_o(rdata_o), .fault_o(fault_o), .replying_i(replying_i),
  .baud_rate_o(baud_rate_o), .ascii_mode_o(ascii_mode_o), .config_ready_o(config_ready_o),
  .outputs_o(outputs_o), .out_led_o(out_led_o), .power_led_o(power_led_o),
  .comm_led_o(comm_led_o)
);

//--- tb/mb_master_model.sv
// Frame-engine model: decoded register requests and message events.
// Assumes the block samples on the rising edge; this model drives on the falling one.
module mb_master_model (
  // clock
  input  wire logic        clk_i,
  // request port
  output logic             req_o,
  output logic             write_o,
  output logic             bit_o,
  output logic [15:0]      addr_o,
  output logic [15:0]      wdata_o,
  input  wire logic        ack_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        fault_i,
  // message events
  output logic [2:0]       events_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {req_o, write_o, bit_o, addr_o, wdata_o, events_o} = '0;
  end

  task automatic xfer(input logic wr, input logic bt, input logic [15:0] a, d,
                      output logic [15:0] rd, output logic flt);
    @(negedge clk_i);
    {req_o, write_o, bit_o, addr_o, wdata_o} = {1'b1, wr, bt, a, d};
    @(negedge clk_i);
    rd = ack_i ? rdata_i : 16'hXXXX;
    flt = ack_i ? fault_i : 1'bx;
    // released lines show the inverse
    {req_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
    @(negedge clk_i);
  endtask : xfer

  // events: bit 2 good message, bit 1 bad packet, bit 0 reply sent
  task automatic pulse(input logic [2:0] ev);
    @(negedge clk_i);
    events_o = ev;
    @(negedge clk_i);
    events_o = 3'h0;
  endtask : pulse
endmodule : mb_master_model

//--- tb/tb_modbus_slave_config_watchdog.sv
// Self-checking bench for the configuration register bank.
// Assumes the master model drives all requests; ms base shortened to 20 cycles.
module tb_modbus_slave_config_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  import mb_cfg_pkg::*;
  logic clk_i, reset_i, rst_sw, req, wr, bt, ack, flt, rep, two_stop, seven, ascii, rdy, pwr, comm;
  logic [4:0]  sw;
  logic [2:0]  ev;
  logic [15:0] addr, wd, rd, dly, outs, leds;
  logic [7:0]  slave;
  logic [19:0] baud;
  parity_e     par;
  int          errors, comparisons, cycles;
  int          rates[7] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200};

  mb_cfg_regs #(.N_OUT(16), .MS_CYCLES(20)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .addr_switch_i(sw), .factory_restore_switch_i(rst_sw),
    .req_i(req), .req_write_i(wr), .req_bit_i(bt), .req_addr_i(addr), .req_wdata_i(wd),
    .ack_o(ack), .rdata_o(rd), .fault_o(flt), .rx_ok_i(ev[2]), .rx_err_i(ev[1]),
    .tx_done_i(ev[0]), .replying_i(rep), .slave_addr_o(slave), .baud_rate_o(baud),
    .parity_o(par), .two_stop_o(two_stop), .seven_data_o(seven), .reply_delay_ms_o(dly),
    .ascii_mode_o(ascii), .config_ready_o(rdy), .outputs_o(outs), .out_led_o(leds),
    .power_led_o(pwr), .comm_led_o(comm)
  );
  mb_master_model u_m (
    .clk_i(clk_i), .req_o(req), .write_o(wr), .bit_o(bt), .addr_o(addr), .wdata_o(wd),
    .ack_i(ack), .rdata_i(rd), .fault_i(flt), .events_o(ev)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [19:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wreg(input logic [15:0] a, d, input logic ef);
    logic [15:0] r;
    logic        f;
    u_m.xfer(1'b1, 1'b0, a, d, r, f);
    chk("fault", 20'(ef), 20'(f));
  endtask : wreg

  task automatic rreg(input logic [15:0] a, exp);
    logic [15:0] r;
    logic        f;
    u_m.xfer(1'b0, 1'b0, a, 16'h0000, r, f);
    chk("rdata", 20'(exp), 20'(r));
  endtask : rreg

  task automatic do_reset(input logic restore);
    @(negedge clk_i);
    {reset_i, rst_sw} = {1'b1, restore};
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
  endtask : do_reset

  task automatic wait_ready();
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge clk_i);
    chk("ready", 20'h1, 20'(rdy));
  endtask : wait_ready

  task automatic t_defaults();
    chk("baud", 20'd19200, baud);
    chk("frame", 20'h0, {two_stop, seven, ascii, 14'h0, 3'(par)});
    chk("delay", 20'h0, 20'(dly));
    rreg(REG_FRAME, RST_FRAME);
    rreg(REG_WATCHDOG, 16'h0000);
    chk("outputs", 20'h0, 20'(outs));
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_config();
    for (int i = 0; i < 7; i++) begin
      wreg(REG_BAUD, 16'(i), 1'b0);
      chk("baud", 20'(rates[i]), baud);
    end
    wreg(REG_BAUD, 16'h0960, 1'b0);
    chk("baud", 20'd24000, baud);
    rreg(REG_BAUD, 16'h0960);
    for (int i = 0; i < 5; i++) begin
      wreg(REG_PARITY, 16'(i), 1'b0);
      chk("parity", 20'(i), 20'(par));
    end
    wreg(REG_FRAME, 16'h0702, 1'b0);
    chk("two stop", 20'h1, 20'(two_stop));
    chk("seven data", 20'h1, 20'(seven));
    wreg(REG_DELAY, 16'h01F4, 1'b0);
    chk("delay", 20'h001F4, 20'(dly));
    wreg(REG_MODE, 16'h0001, 1'b0);
    chk("ascii", 20'h1, 20'(ascii));
    wreg(REG_MODE, 16'h0000, 1'b0);
    chk("ascii", 20'h0, 20'(ascii));
    $display("test config done");
  endtask : t_config

  task automatic t_addr();
    logic [15:0] r;
    logic        f;
    for (int i = 0; i < 32; i++) begin
      sw = 5'(i);
      repeat (5) @(negedge clk_i);
      chk("switch addr", 20'(i), 20'(slave));
    end
    sw = 5'h05;
    wreg(REG_SOFT_ADDR, 16'h0040, 1'b0);
    chk("soft addr", 20'h40, 20'(slave));
    wreg(REG_SOFT_ADDR, 16'h00FF, 1'b0);
    chk("soft addr", 20'hFF, 20'(slave));
    wreg(REG_SOFT_ADDR, 16'h001F, 1'b0);
    chk("switch addr", 20'h05, 20'(slave));
    wreg(REG_VERSION, 16'h0000, 1'b1);
    wreg(16'h0007, 16'h0000, 1'b1);
    u_m.xfer(1'b1, 1'b1, BIT_OUT_BASE + 16'h3, 16'h0001, r, f);
    chk("outputs", 20'h0008, 20'(outs));
    u_m.xfer(1'b0, 1'b1, BIT_OUT_BASE + 16'h3, 16'h0000, r, f);
    chk("bit read", 20'h1, 20'(r[0]));
    $display("test address done");
  endtask : t_addr

  task automatic t_wdog();
    wreg(REG_DEF_OUT, 16'h00A5, 1'b0);
    wreg(REG_OUTPUTS, 16'h0F00, 1'b0);
    wreg(REG_WATCHDOG, 16'h0002, 1'b0);
    for (int i = 0; i < 10; i++) begin
      u_m.pulse(3'h4);
      repeat (8) @(negedge clk_i);
    end
    repeat (13) @(negedge clk_i);
    chk("outputs", 20'h0F00, 20'(outs));
    for (int i = 0; i < 60 && outs !== 16'h00A5; i++) @(negedge clk_i);
    chk("outputs", 20'h00A5, 20'(outs));
    chk("leds", 20'h00A5, 20'(leds));
    wreg(REG_WATCHDOG, 16'h0000, 1'b0);
    wreg(REG_OUTPUTS, 16'h1234, 1'b0);
    repeat (100) @(negedge clk_i);
    chk("outputs", 20'h1234, 20'(outs));
    u_m.pulse(3'h3);
    rreg(REG_RX_LSB, 16'h000A);
    rreg(REG_ERR_LSB, 16'h0001);
    rreg(REG_TX_LSB, 16'h0001);
    @(negedge clk_i);
    rep = 1'b1;
    @(negedge clk_i);
    chk("comm led", 20'h1, 20'(comm));
    rep = 1'b0;
    @(negedge clk_i);
    chk("comm led", 20'h0, 20'(comm));
    $display("test watchdog done");
  endtask : t_wdog

  task automatic t_restore();
    wreg(REG_BAUD, 16'h0005, 1'b0);
    do_reset(1'b1);
    repeat (10) @(negedge clk_i);
    chk("ready", 20'h0, 20'(rdy));
    chk("power led", 20'h1, 20'(pwr));
    wreg(REG_BAUD, 16'h0004, 1'b1);
    for (int i = 0; i < 6000 && pwr !== 1'b0; i++) @(negedge clk_i);
    chk("power led", 20'h0, 20'(pwr));
    rst_sw = 1'b0;
    repeat (4) @(negedge clk_i);
    wait_ready();
    rreg(REG_BAUD, RST_BAUD);
    rreg(REG_DEF_OUT, 16'h0000);
    $display("test restore done");
  endtask : t_restore

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    {reset_i, rst_sw, sw, rep} = 8'h80;
    do_reset(1'b0);
    wait_ready();
    t_defaults();
    t_config();
    t_addr();
    t_wdog();
    t_restore();
    test_done();
  end
endmodule : tb_modbus_slave_config_watchdog
